// *** logic/tou_defines.svh ***
`ifndef TOU_DEFINES_SVH
`define TOU_DEFINES_SVH
// register indices on the plain port
`define TOU_ADDR_CTRL0 4'h0
`define TOU_ADDR_IVEC 4'h8
`define TOU_ADDR_FLAGS 4'h9
`define TOU_ADDR_FSET 4'hA
`define TOU_ADDR_FCLR 4'hB
`define TOU_ADDR_OUTS 4'hC
// channel control field positions
`define TOU_CTL_OUT_BIT 0
`define TOU_CTL_IE_BIT 1
`define TOU_CTL_MODE_LSB 2
// flags word: overflow flag above the channel flags
`define TOU_FLAG_OVF_BIT 7
`define TOU_OVF_IE_BIT 8
// vector codes
`define TOU_IV_NONE 4'h0
`define TOU_IV_OVF 4'hE
`define TOU_RST_CTL 16'h0000
`endif

// *** logic/tou_pkg.sv ***
package tou_pkg;
  typedef enum logic [2:0] {
    TOU_M_OUT, TOU_M_SET, TOU_M_TGL_RST, TOU_M_SET_RST,
    TOU_M_TGL, TOU_M_RST, TOU_M_TGL_SET, TOU_M_RST_SET
  } tou_mode_t;
endpackage

// *** logic/tou_out_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tou_defines.svh"
module tou_out_unit (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // controls
  input wire logic [2:0] output_mode_field,
  input wire logic out_bit,
  input wire logic channel_match_event,
  input wire logic period_match_event,
  input wire logic timer_clear,
  // result
  output logic channel_output
);
  typedef struct packed {
    logic q;
  } tou_ou_st_t;
  tou_ou_st_t s_q, s_d;
  tou_pkg::tou_mode_t m;
  assign m = tou_pkg::tou_mode_t'(output_mode_field);
  always_comb begin
    s_d = s_q;
    case (m)
      tou_pkg::TOU_M_OUT: s_d.q = out_bit;
      tou_pkg::TOU_M_SET: begin
        if (timer_clear) s_d.q = 1'b0;
        else if (channel_match_event) s_d.q = 1'b1;
      end
      tou_pkg::TOU_M_TGL_RST: begin
        if (period_match_event) s_d.q = 1'b0;
        else if (channel_match_event) s_d.q = ~s_q.q;
      end
      tou_pkg::TOU_M_SET_RST: begin
        if (period_match_event) s_d.q = 1'b0;
        else if (channel_match_event) s_d.q = 1'b1;
      end
      tou_pkg::TOU_M_TGL: if (channel_match_event) s_d.q = ~s_q.q;
      tou_pkg::TOU_M_RST: if (channel_match_event) s_d.q = 1'b0;
      tou_pkg::TOU_M_TGL_SET: begin
        if (period_match_event) s_d.q = 1'b1;
        else if (channel_match_event) s_d.q = ~s_q.q;
      end
      tou_pkg::TOU_M_RST_SET: begin
        if (period_match_event) s_d.q = 1'b1;
        else if (channel_match_event) s_d.q = 1'b0;
      end
      default: s_d = s_q;
    endcase
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end
  assign channel_output = (m == tou_pkg::TOU_M_OUT) ? out_bit : s_q.q;
endmodule
`default_nettype wire

// *** logic/tou_top.sv ***
// Functional notes
// - each channel owns an eight-mode output unit
// - high hiz pin tristates all outputs
// - outputs change on clock edge only
// - mode zero follows out bit immediately
// - set mode holds until timer clear, reset mode is sticky
// - paired modes act on both matches; channel zero takes its own match as the period match
// - toggle mode ignores period match
// - up mode period event is rollover
// - up/down matches in both directions
// - two interrupt requests provided
// - flags set by match, capture, software
// - request needs enable and global enable
// - channel zero flag cleared on acknowledge
// - vector shows highest enabled pending source except channel zero
// - vector access clears reported flag
// - even codes, lower wins, overflow fourteen
// - compare match raises event and flag
`timescale 1ns/1ps
`default_nettype none
`include "tou_defines.svh"
module tou_top #(
  parameter int NCH = 7,
  parameter int CW = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // timer state from counter
  input wire logic [CW-1:0] count_value,
  input wire logic counting,
  input wire logic up_mode,
  input wire logic timer_clear,
  input wire logic overflow_event,
  input wire logic [CW-1:0] period_latch,
  input wire logic [NCH*CW-1:0] channel_compare_latch,
  input wire logic [NCH-1:0] capture_mode,
  input wire logic [NCH-1:0] capture_event,
  // cpu side
  input wire logic global_irq_enable,
  input wire logic irq0_ack,
  output logic irq0,
  output logic irq_shared,
  // tristate pin function
  input wire logic outputs_hiz_pin_function,
  input wire logic hiz_pin,
  // channel outputs
  output logic [NCH-1:0] channel_output,
  output logic [NCH-1:0] channel_output_oe
);
  typedef struct packed {
    logic [2:0] pin;
    logic [NCH-1:0][15:0] ctl;
    logic [NCH-1:0] flag;
    logic ovf_flag;
    logic ovf_ie;
    logic [CW-1:0] last_count;
    logic [15:0] rdata;
  } tou_st_t;
  tou_st_t s_q, s_d;
  logic rst_n;
  logic [1:0] rs_q;
  logic [NCH-1:0] ch_match, ie, out_raw;
  logic [3:0] iv;
  logic hiz;

  // reset released through two flops, kept apart from the state word
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs_q <= 2'b00;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  // priority encoder, used for read and for clear
  function automatic logic [3:0] ivec(
    input logic [NCH-1:0] f,
    input logic [NCH-1:0] e,
    input logic of,
    input logic oe
  );
    logic [3:0] r;
    r = `TOU_IV_NONE;
    if (of && oe) begin
      r = `TOU_IV_OVF;
    end
    // channel 1 scanned last so it wins; channel 0 is not scanned
    for (int i = NCH - 1; i >= 1; i--) begin
      if (f[i] && e[i]) begin
        r = 4'(2 * i);
      end
    end
    return r;
  endfunction

  // equal and moved since last cycle: a count held still matches once
  function automatic logic hit(
    input logic [CW-1:0] cnt,
    input logic [CW-1:0] last,
    input logic [CW-1:0] lat
  );
    return (cnt == lat) && (cnt != last);
  endfunction

  always_comb begin
    ch_match = '0;
    ie = '0;
    for (int i = 0; i < NCH; i++) begin
      ie[i] = s_q.ctl[i][`TOU_CTL_IE_BIT];
      if (counting && !capture_mode[i]) begin
        ch_match[i] = hit(count_value, s_q.last_count,
                          channel_compare_latch[i*CW +: CW]);
      end
    end
  end

  logic period_ev;
  // rollover to zero in up mode
  always_comb begin
    period_ev = 1'b0;
    if (counting) begin
      if (up_mode) begin
        period_ev = (count_value == '0) && (s_q.last_count == period_latch);
      end else begin
        period_ev = hit(count_value, s_q.last_count, period_latch);
      end
    end
  end

  assign iv = ivec(s_q.flag, ie, s_q.ovf_flag, s_q.ovf_ie);

  always_comb begin
    s_d = s_q;
    s_d.last_count = count_value;
    // three stage pin sampling
    s_d.pin = {s_q.pin[1:0], hiz_pin};
    // software writes first so hardware sets win
    if (wr) begin
      if (addr < 4'(NCH)) begin
        s_d.ctl[addr[2:0]] = wdata;
      end
      case (addr)
        `TOU_ADDR_FSET: begin
          s_d.flag = s_q.flag | wdata[NCH-1:0];
          s_d.ovf_flag = s_q.ovf_flag | wdata[`TOU_FLAG_OVF_BIT];
        end
        `TOU_ADDR_FCLR: begin
          s_d.flag = s_q.flag & ~wdata[NCH-1:0];
          s_d.ovf_flag = s_q.ovf_flag & ~wdata[`TOU_FLAG_OVF_BIT];
        end
        `TOU_ADDR_FLAGS: begin
          s_d.ovf_ie = wdata[`TOU_OVF_IE_BIT];
        end
        default: begin
        end
      endcase
    end
    if ((wr || rd) && addr == `TOU_ADDR_IVEC) begin
      if (iv == `TOU_IV_OVF) begin
        s_d.ovf_flag = 1'b0;
      end else if (iv != `TOU_IV_NONE) begin
        s_d.flag[iv[3:1]] = 1'b0;
      end
    end
    if (irq0_ack) begin
      s_d.flag[0] = 1'b0;
    end
    s_d.flag = s_d.flag | ch_match | (capture_event & capture_mode);
    if (overflow_event) begin
      s_d.ovf_flag = 1'b1;
    end
    // read data stands one cycle, zero otherwise
    s_d.rdata = 16'h0000;
    if (rd) begin
      if (addr < 4'(NCH)) begin
        s_d.rdata = s_q.ctl[addr[2:0]];
      end else begin
        case (addr)
          `TOU_ADDR_IVEC: s_d.rdata = {12'h000, iv};
          `TOU_ADDR_FLAGS: begin
            s_d.rdata = 16'({s_q.ovf_ie, s_q.ovf_flag, s_q.flag});
          end
          `TOU_ADDR_OUTS: s_d.rdata = 16'(channel_output);
          default: s_d.rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q.pin <= '0;
      s_q.ctl <= '0;
      s_q.flag <= '0;
      s_q.ovf_flag <= 1'b0;
      s_q.ovf_ie <= 1'b0;
      s_q.last_count <= '0;
      s_q.rdata <= '0;
    end else begin
      s_q.pin <= s_d.pin;
      s_q.ctl <= s_d.ctl;
      s_q.flag <= s_d.flag;
      s_q.ovf_flag <= s_d.ovf_flag;
      s_q.ovf_ie <= s_d.ovf_ie;
      s_q.last_count <= s_d.last_count;
      s_q.rdata <= s_d.rdata;
    end
  end
  assign rdata = s_q.rdata;

  assign irq0 = s_q.flag[0] && ie[0] && global_irq_enable;
  // pending enabled source other than channel 0 drives shared line
  assign irq_shared = (iv != `TOU_IV_NONE) && global_irq_enable;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ou
      tou_out_unit u_ou (
        .clock(clock),
        .rst_n(rst_n),
        .output_mode_field(s_q.ctl[g][`TOU_CTL_MODE_LSB +: 3]),
        .out_bit(s_q.ctl[g][`TOU_CTL_OUT_BIT]),
        .channel_match_event(ch_match[g]),
        .period_match_event(g == 0 ? ch_match[0] : period_ev),
        .timer_clear(timer_clear),
        .channel_output(out_raw[g])
      );
    end
  endgenerate

  // agreed pin level forces high impedance
  assign hiz = outputs_hiz_pin_function && s_q.pin[2] && s_q.pin[1];
  assign channel_output = out_raw;
  assign channel_output_oe = {NCH{~hiz}};
endmodule
`default_nettype wire

// *** dv/tou_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tou_props #(
  parameter int NCH = 7
) (
  // clock, reset, register port
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // timer and cpu side
  input wire logic counting,
  input wire logic timer_clear,
  input wire logic [NCH-1:0] capture_event,
  input wire logic global_irq_enable,
  input wire logic irq0_ack,
  input wire logic irq0,
  input wire logic irq_shared,
  // pins
  input wire logic outputs_hiz_pin_function,
  input wire logic hiz_pin,
  input wire logic [NCH-1:0] channel_output,
  input wire logic [NCH-1:0] channel_output_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // pin passes a three stage sync, so allow five samples
  hiz_on_a: assert property (
    (outputs_hiz_pin_function && hiz_pin) [*5] |-> channel_output_oe == '0
  ) else $error("outputs driven while tristated");
  hiz_off_a: assert property (
    !outputs_hiz_pin_function [*5] |-> &channel_output_oe
  ) else $error("outputs tristated without pin function");
  irq0_gate_a: assert property (
    irq0 |-> global_irq_enable) else $error("irq0 without global enable");
  shared_gate_a: assert property (
    irq_shared |-> global_irq_enable) else $error("shared irq ungated");
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == '0) else $error("read data outside slot");
  vec_code_a: assert property (
    $past(rd && addr == 4'h8) |-> !rdata[0] && rdata <= 16'h000e
  ) else $error("bad vector code");
  // a hardware set in the same cycle would win, so exclude it
  ack_clear_a: assert property (
    irq0 && irq0_ack && !counting && !wr && !capture_event[0] |=> !irq0
  ) else $error("irq0 kept after acknowledge");
  out_cause_a: assert property (
    $changed(channel_output) |-> $past(wr || counting || timer_clear)
  ) else $error("output changed without cause");
endmodule
bind tou_top tou_props #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// *** dv/timer_output_unit_irq_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_output_unit_irq_tb_top;
  logic clock, nrst, wr, rd, counting, up_mode, timer_clear, overflow_event;
  logic global_irq_enable, irq0_ack, irq0, irq_shared, hiz_pin;
  logic outputs_hiz_pin_function;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, v, count_value, period_latch;
  logic [111:0] channel_compare_latch;
  logic [6:0] capture_mode, capture_event, channel_output, channel_output_oe;
  int miscompares, total_checks, cyc;
  // rows: mode, level after channel match, level after period match
  localparam logic [4:0] ROWS [8] = '{5'h07, 5'h14, 5'h0a, 5'h0e, 5'h13,
    5'h19, 5'h1d, 5'h00};
  localparam logic [15:0] IV [4] = '{16'h0004, 16'h000a, 16'h000e, 16'h0000};
  tou_top u_dut (.*);
  task automatic chk(input string n, input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrt(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic tick(input logic [15:0] c);
    @(posedge clock);
    count_value <= c;
    @(posedge clock);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      give_verdict;
    end
  end
  initial begin
    {nrst, wr, rd, counting, up_mode, timer_clear, overflow_event} = '0;
    {global_irq_enable, irq0_ack, outputs_hiz_pin_function, hiz_pin} = '0;
    {addr, wdata, count_value, capture_mode, capture_event} = '0;
    period_latch = 16'h0009;
    channel_compare_latch = {{80{1'b1}}, 16'h0005, 16'h0009};
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("rst out", channel_output, 7'h00);
    chk("rst oe", channel_output_oe, 7'h7f);
    rdr(4'h9);
    chk("rst flags", v, 16'h0000);
    @(posedge clock);
    counting <= 1'b1;
    foreach (ROWS[i]) begin
      wrt(4'h1, 16'h001c);
      wrt(4'h1, {11'h000, ROWS[i][4:2], 2'b00});
      tick(16'h0005);
      chk("ch match", channel_output[1], ROWS[i][1]);
      tick(16'h0009);
      chk("per match", channel_output[1], ROWS[i][0]);
    end
    @(posedge clock);
    up_mode <= 1'b1;
    wrt(4'h1, 16'h001c);
    wrt(4'h1, 16'h000c);
    tick(16'h0005);
    tick(16'h0009);
    chk("up at period", channel_output[1], 1'b1);
    tick(16'h0000);
    chk("up rollover", channel_output[1], 1'b0);
    wrt(4'h1, 16'h001c);
    wrt(4'h1, 16'h0010);
    tick(16'h0006);
    tick(16'h0005);
    chk("down match", channel_output[1], 1'b1);
    tick(16'h0004);
    tick(16'h0005);
    chk("up match", channel_output[1], 1'b0);
    wrt(4'h1, 16'h001c);
    wrt(4'h1, 16'h0004);
    tick(16'h0006);
    tick(16'h0005);
    chk("set mode", channel_output[1], 1'b1);
    @(posedge clock);
    timer_clear <= 1'b1;
    @(posedge clock);
    timer_clear <= 1'b0;
    #1 chk("set cleared", channel_output[1], 1'b0);
    wrt(4'h1, 16'h0001);
    chk("mode zero", channel_output[1], 1'b1);
    @(posedge clock);
    {outputs_hiz_pin_function, hiz_pin} <= 2'b11;
    repeat (6) @(posedge clock);
    #1 chk("hiz", channel_output_oe, 7'h00);
    @(posedge clock);
    {outputs_hiz_pin_function, counting, global_irq_enable} <= 3'b001;
    repeat (6) @(posedge clock);
    #1 chk("no hiz", channel_output_oe, 7'h7f);
    wrt(4'hb, 16'h00ff);
    wrt(4'h0, 16'h0002);
    wrt(4'ha, 16'h0001);
    chk("irq0 set", irq0, 1'b1);
    @(posedge clock);
    global_irq_enable <= 1'b0;
    #1 chk("irq0 gie", irq0, 1'b0);
    @(posedge clock);
    {global_irq_enable, irq0_ack} <= 2'b11;
    @(posedge clock);
    irq0_ack <= 1'b0;
    #1 chk("irq0 ack", irq0, 1'b0);
    wrt(4'h2, 16'h0002);
    wrt(4'h5, 16'h0002);
    wrt(4'h9, 16'h0100);
    wrt(4'ha, 16'h00a6);
    chk("shared", irq_shared, 1'b1);
    foreach (IV[i]) begin
      rdr(4'h8);
      chk("vector", v, IV[i]);
    end
    chk("shared idle", irq_shared, 1'b0);
    @(posedge clock);
    {overflow_event, capture_mode[3], capture_event[3]} <= 3'b111;
    @(posedge clock);
    {overflow_event, capture_event[3]} <= 2'b00;
    rdr(4'h9);
    chk("flags", v, 16'h018a);
    wrt(4'h8, 16'h0000);
    rdr(4'h9);
    chk("vector write", v, 16'h010a);
    rdr(4'hc);
    chk("out levels", v, 16'h0002);
    rdr(4'h7);
    chk("unmapped", v, 16'h0000);
    give_verdict;
  end
endmodule
`default_nettype wire
